// ==== tweep_defs.vh ====
// constants shared by the two-wire eeprom target
`ifndef TWEEP_DEFS_VH
`define TWEEP_DEFS_VH

`define TWEEP_DEV_CODE    4'hA
`define TWEEP_ADDR_W      13
`define TWEEP_PAGE_W      8
`define TWEEP_OFS_W       5
`define TWEEP_PAGE_BYTES  6'h20
`define TWEEP_LAST_BIT    4'h8
`define TWEEP_ACK_DONE    4'h9
`define TWEEP_BIT_ZERO    4'h0
`define TWEEP_HI_ADDR_W   5
`define TWEEP_TWR_US      5000
`define TWEEP_CLK_MHZ     25
`define TWEEP_SYNC_LAT    3
`define TWEEP_SYNC_W      6
`define TWEEP_SYNC_RST    6'h03

`endif

// ==== tweep_sync.v ====
// two-flop synchroniser for the asynchronous pins
`default_nettype none
`include "tweep_defs.vh"

module tweep_sync #(
   parameter                  WIDTH   = `TWEEP_SYNC_W,
   parameter [WIDTH-1:0]      RST_VAL = `TWEEP_SYNC_RST
) (
   input  wire                clk,
   input  wire                rstn,
   input  wire [WIDTH-1:0]    pinIn,
   output reg  [WIDTH-1:0]    pinSync
);

   reg [WIDTH-1:0] firstStage;

   // first stage feeds only the second stage
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         firstStage <= RST_VAL;
         pinSync    <= RST_VAL;
      end else begin
         firstStage <= pinIn;
         pinSync    <= firstStage;
      end
   end

endmodule
`default_nettype wire

// ==== tweep_mem.v ====
// byte-wide array of the whole memory, one write and one read port
`default_nettype none
`include "tweep_defs.vh"

module tweep_mem (
   input  wire                       clk,
   input  wire                       wrEn,
   input  wire [`TWEEP_ADDR_W-1:0]   wrAddr,
   input  wire [7:0]                 wrData,
   input  wire [`TWEEP_ADDR_W-1:0]   rdAddr,
   output reg  [7:0]                 rdData
);

   reg [7:0] cells [0:(1<<`TWEEP_ADDR_W)-1];

   // a write simply replaces the byte, no erase step
   always @(posedge clk) begin
      if (wrEn) begin
         cells[wrAddr] <= wrData;
      end
      rdData <= cells[rdAddr];
   end

endmodule
`default_nettype wire

// ==== tweep_core.v ====
// two-wire serial eeprom target: bus protocol, page buffer, write timing
`default_nettype none
`include "tweep_defs.vh"

// Operation
// - sample on clock rise, drive on fall
// - open chip-select pins compare as low; here the board must pull them low, no internal pull-down
// - write-protect high blocks all programming
// - thirteen-bit byte address, 256 pages of 32
// - start condition recognised at any time except during the internal write cycle
// - stop ends command; write waits for programming
// - acknowledge low on ninth clock per byte
// - first byte 1010 plus chip-select match
// - eighth address bit selects read or write
// - byte write: two address bytes, data, stop
// - ignore bus during internal write cycle
// - internal write finishes within 5 ms
// - page write up to 32 data bytes
// - in a write only low five address bits increment
// - partial page programs only received bytes
// - no address acknowledge while programming
// - counter holds last address plus one
// - current read outputs counter byte, increments
// - writes overwrite without separate erase
// - standby right after reset
// - controller nack then stop ends read
// - acknowledged read continues, counter wraps at top
// - new start aborts pending write, keeps counter
module tweep_core #(
   parameter integer WRITE_CYCLES = `TWEEP_TWR_US * `TWEEP_CLK_MHZ
) (
   input  wire        clk,
   input  wire        rstn,
   input  wire        sclIn,
   input  wire        sdaIn,
   output wire        sdaOut,
   output wire        sdaOe,
   input  wire        chip_select_bit_high,
   input  wire        chip_select_bit_mid,
   input  wire        chip_select_bit_low,
   input  wire        wpIn,
   output wire        progBusy,
   output wire        standby
);

   ////////////////////////////////////////////////////////////////////////////
   localparam [6:0] S_IDLE = 7'h01;
   localparam [6:0] S_DEV  = 7'h02;
   localparam [6:0] S_AHI  = 7'h04;
   localparam [6:0] S_ALO  = 7'h08;
   localparam [6:0] S_WDAT = 7'h10;
   localparam [6:0] S_RDAT = 7'h20;
   localparam [6:0] S_SKIP = 7'h40;

   // counted from the pin edge, so the sync delay is taken off
   localparam integer WAIT_LAST = WRITE_CYCLES - `TWEEP_SYNC_LAT - 1;

   ////////////////////////////////////////////////////////////////////////////
   wire [`TWEEP_SYNC_W-1:0] pinSync;
   wire                     sclS;
   wire                     sdaS;
   wire                     wpS;
   wire [2:0]               csS;

   reg                      sclQ;
   reg                      sdaQ;
   reg  [6:0]               state;
   reg  [3:0]               bitCnt;
   reg  [7:0]               shiftIn;
   reg  [7:0]               txByte;
   reg                      driveLow;
   reg                      rwRead;
   reg  [`TWEEP_ADDR_W-1:0] addrCnt;
   reg  [`TWEEP_PAGE_W-1:0] pageAddr;
   reg  [31:0]              byteMask;
   reg                      busy;
   reg  [5:0]               progIdx;
   reg  [31:0]              waitCnt;
   reg                      sdaZero;
   reg  [7:0]               pageBuf [0:31];

   wire                     sclRise;
   wire                     sclFall;
   wire                     startSeen;
   wire                     stopSeen;
   wire                     devMatch;
   wire                     bufWe;
   wire                     readLoad;
   wire [7:0]               memRd;
   wire                     memWe;
   wire [`TWEEP_ADDR_W-1:0] memWrAddr;
   wire [7:0]               memWrData;

   ////////////////////////////////////////////////////////////////////////////
   // pins: sda, scl, chip selects, write protect
   tweep_sync #(
      .WIDTH   (`TWEEP_SYNC_W),
      .RST_VAL (`TWEEP_SYNC_RST)
   ) u_sync (
      .clk     (clk),
      .rstn    (rstn),
      .pinIn   ({wpIn, chip_select_bit_high, chip_select_bit_mid,
                 chip_select_bit_low, sclIn, sdaIn}),
      .pinSync (pinSync)
   );

   assign sdaS = pinSync[0];
   assign sclS = pinSync[1];
   // open pins must be pulled low on the board; logic sees a plain low
   assign csS  = pinSync[4:2];
   assign wpS  = pinSync[5];

   ////////////////////////////////////////////////////////////////////////////
   // line events, all on synchronised levels
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclQ <= 1'b1;
         sdaQ <= 1'b1;
      end else begin
         sclQ <= sclS;
         sdaQ <= sdaS;
      end
   end

   assign sclRise   = sclS & ~sclQ;
   assign sclFall   = ~sclS & sclQ;
   // data moving while clock high is a condition, never a bit
   assign startSeen = sclS & sclQ & sdaQ & ~sdaS;
   assign stopSeen  = sclS & sclQ & ~sdaQ & sdaS;

   assign devMatch  = (shiftIn[7:4] == `TWEEP_DEV_CODE) &&
                      (shiftIn[3:1] == csS);

   // fall that ends the ninth clock of a read device byte or of an acknowledged read data byte
   assign readLoad  = sclFall && (bitCnt == `TWEEP_ACK_DONE) &&
                      ((state == S_DEV && rwRead) || state == S_RDAT);

   assign bufWe     = ~busy & ~startSeen & ~stopSeen & ~sclRise & sclFall &
                      (bitCnt == `TWEEP_LAST_BIT) & (state == S_WDAT);

   ////////////////////////////////////////////////////////////////////////////
   // protocol engine
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state    <= S_IDLE;
         bitCnt   <= `TWEEP_BIT_ZERO;
         shiftIn  <= 8'h00;
         txByte   <= 8'h00;
         driveLow <= 1'b0;
         rwRead   <= 1'b0;
         addrCnt  <= 13'h0000;
         pageAddr <= 8'h00;
         byteMask <= 32'h00000000;
         busy     <= 1'b0;
         progIdx  <= 6'h00;
         waitCnt  <= 32'h00000000;
      end else if (busy) begin
         // the bus is deaf here, so no address byte is ever acknowledged
         driveLow <= 1'b0;
         state    <= S_IDLE;
         if (progIdx != `TWEEP_PAGE_BYTES) begin
            progIdx <= progIdx + 6'h01;
         end
         waitCnt <= waitCnt + 32'h00000001;
         if (waitCnt == WAIT_LAST) begin
            busy     <= 1'b0;
            byteMask <= 32'h00000000;
         end
      end else if (startSeen) begin
         // a pending write is dropped; the counter keeps its load
         state    <= S_DEV;
         bitCnt   <= `TWEEP_BIT_ZERO;
         driveLow <= 1'b0;
         byteMask <= 32'h00000000;
      end else if (stopSeen) begin
         state    <= S_IDLE;
         driveLow <= 1'b0;
         if (state == S_WDAT && byteMask != 32'h00000000 && !wpS) begin
            busy    <= 1'b1;
            progIdx <= 6'h00;
            waitCnt <= 32'h00000000;
         end else begin
            byteMask <= 32'h00000000;
         end
      end else if (sclRise) begin
         if (bitCnt < `TWEEP_LAST_BIT) begin
            shiftIn <= {shiftIn[6:0], sdaS};
            bitCnt  <= bitCnt + 4'h1;
         end else if (bitCnt == `TWEEP_LAST_BIT) begin
            bitCnt <= `TWEEP_ACK_DONE;
            if (state == S_RDAT && sdaS) begin
               state <= S_SKIP;
            end
         end
      end else if (sclFall) begin
         if (bitCnt == `TWEEP_LAST_BIT) begin
            case (state)
               S_DEV: begin
                  rwRead <= shiftIn[0];
                  if (devMatch) begin
                     driveLow <= 1'b1;
                  end else begin
                     state    <= S_SKIP;
                     driveLow <= 1'b0;
                  end
               end
               S_AHI: begin
                  // top three bits of the high byte are don't care
                  addrCnt[`TWEEP_ADDR_W-1:8] <= shiftIn[`TWEEP_HI_ADDR_W-1:0];
                  driveLow <= 1'b1;
               end
               S_ALO: begin
                  addrCnt[7:0] <= shiftIn;
                  driveLow     <= 1'b1;
               end
               S_WDAT: begin
                  byteMask[addrCnt[`TWEEP_OFS_W-1:0]] <= 1'b1;
                  pageAddr <= addrCnt[`TWEEP_ADDR_W-1:`TWEEP_OFS_W];
                  // page bits stay, so a long burst wraps and overwrites
                  addrCnt[`TWEEP_OFS_W-1:0] <= addrCnt[`TWEEP_OFS_W-1:0] + 5'h01;
                  driveLow <= 1'b1;
               end
               default: begin
                  // read data done: free the line for the controller's answer
                  driveLow <= 1'b0;
               end
            endcase
         end else if (bitCnt == `TWEEP_ACK_DONE) begin
            bitCnt <= `TWEEP_BIT_ZERO;
            case (state)
               S_DEV: begin
                  if (rwRead) begin
                     state <= S_RDAT;
                  end else begin
                     state <= S_AHI;
                  end
               end
               S_AHI: begin
                  state <= S_ALO;
               end
               S_ALO: begin
                  state <= S_WDAT;
               end
               default: begin
                  state <= state;
               end
            endcase
            if (readLoad) begin
               txByte   <= memRd;
               driveLow <= ~memRd[7];
               addrCnt  <= addrCnt + 13'h0001;
            end else begin
               driveLow <= 1'b0;
            end
         end else if (state == S_RDAT && bitCnt != `TWEEP_BIT_ZERO) begin
            txByte   <= {txByte[6:0], 1'b0};
            driveLow <= ~txByte[6];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // page buffer: bytes gather here until the stop, then burn in one pass
   always @(posedge clk) begin
      if (bufWe) begin
         pageBuf[addrCnt[`TWEEP_OFS_W-1:0]] <= shiftIn;
      end
   end

   // only bytes that were received are written back
   assign memWe     = busy && (progIdx != `TWEEP_PAGE_BYTES) &&
                      byteMask[progIdx[`TWEEP_OFS_W-1:0]];
   assign memWrAddr = {pageAddr, progIdx[`TWEEP_OFS_W-1:0]};
   assign memWrData = pageBuf[progIdx[`TWEEP_OFS_W-1:0]];

   tweep_mem u_mem (
      .clk    (clk),
      .wrEn   (memWe),
      .wrAddr (memWrAddr),
      .wrData (memWrData),
      .rdAddr (addrCnt),
      .rdData (memRd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // open drain: only ever pulls low
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sdaZero <= 1'b0;
      end else begin
         sdaZero <= 1'b0;
      end
   end

   assign sdaOut   = sdaZero;
   assign sdaOe    = driveLow;
   assign progBusy = busy;
   assign standby  = ~busy & ((state == S_IDLE) | (state == S_SKIP));

endmodule
`default_nettype wire

// ==== tweep_ctrl.sv ====
// bus controller model: drives serial clock and open-drain data
`default_nettype none
module tweep_ctrl (
   input  wire logic clk,
   input  wire logic sdaWire,
   output var  logic scl,
   output var  logic sdaDrv
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge clk);
   endtask
   // data moves only in the low half; one bit is 8 clocks
   task automatic bitx(input logic b, output logic r);
      hold(2);
      sdaDrv = b;
      hold(2);
      scl = 1'b1;
      hold(2);
      r = sdaWire;
      hold(2);
      scl = 1'b0;
   endtask
   task automatic start;
      hold(2);
      sdaDrv = 1'b1;
      hold(2);
      scl = 1'b1;
      hold(4);
      sdaDrv = 1'b0;
      hold(4);
      scl = 1'b0;
   endtask
   task automatic stop;
      hold(2);
      sdaDrv = 1'b0;
      hold(2);
      scl = 1'b1;
      hold(4);
      sdaDrv = 1'b1;
      hold(4);
   endtask
   // msb first, ninth clock carries the acknowledge either way
   task automatic xfer(input logic [7:0] d, input logic ackIn,
                       output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(ackIn, ack);
   endtask
endmodule
`default_nettype wire

// ==== tweep_assertions.sv ====
// pin-level checks of the eeprom target
`default_nettype none
module tweep_assertions #(
   parameter integer WRITE_CYCLES = 100
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic chip_select_bit_high,
   input wire logic chip_select_bit_mid,
   input wire logic chip_select_bit_low,
   input wire logic wpIn,
   input wire logic progBusy,
   input wire logic standby
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rstn);
   localparam int BUSY_N = WRITE_CYCLES - 3;
   int busyLen;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) busyLen <= 0;
      else if (progBusy) busyLen <= busyLen + 1;
      else busyLen <= 0;
   end
   ////////////////////////////////////////////////////////////
   AST_OPEN_DRAIN: assert property (sdaOe |-> !sdaOut)
      else $error("data pin driven high");
   // sync latency puts every drive change 3 edges after a clock fall
   AST_OE_EDGE: assert property ($changed(sdaOe) |-> $past(sclIn, 4) && !$past(sclIn, 3))
      else $error("data drive changed off a clock fall");
   AST_BUSY_QUIET: assert property (progBusy |-> !sdaOe && !standby)
      else $error("bus answered while programming");
   AST_BUSY_LEN: assert property ($fell(progBusy) |-> busyLen == BUSY_N)
      else $error("write cycle length wrong");
   AST_BUSY_HOLD: assert property ($rose(progBusy) |=> progBusy [*8])
      else $error("write cycle cut short");
   AST_BUSY_CAUSE: assert property ($rose(progBusy) |-> sclIn && sdaIn && !wpIn)
      else $error("programming without stop or under protect");
   AST_IDLE_RELEASED: assert property (standby |-> !sdaOe)
      else $error("data driven in standby");
   AST_STANDBY_AFTER: assert property ($fell(progBusy) |-> standby)
      else $error("no standby after programming");
   cover property ($fell(progBusy));
   cover property ($rose(sdaOe));
   cover property (wpIn && sclIn && $rose(sdaIn));
endmodule
bind tweep_core tweep_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
   .clk(clk), .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
   .chip_select_bit_high(chip_select_bit_high), .chip_select_bit_mid(chip_select_bit_mid),
   .chip_select_bit_low(chip_select_bit_low), .wpIn(wpIn), .progBusy(progBusy),
   .standby(standby));
`default_nettype wire

// ==== two_wire_serial_eeprom_8k_bytes_bench.sv ====
// self-checking bench of the eeprom target against a byte model
`default_nettype none
module two_wire_serial_eeprom_8k_bytes_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int WC = 100;
   logic       clk, rstn, scl, sdaDrv, sda, sdaOut, sdaOe, wp, busy, stby, ack;
   logic [2:0] cs;
   logic [7:0] q;
   logic [7:0] mdl [int];
   int         miscompares, testsRun, seed, cnt;
   // pull-up wire: low if either side pulls
   assign sda = sdaDrv & ~sdaOe;
   tweep_ctrl ctrl (.clk(clk), .sdaWire(sda), .scl(scl), .sdaDrv(sdaDrv));
   tweep_core #(.WRITE_CYCLES(WC)) uut (
      .clk(clk), .rstn(rstn), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .chip_select_bit_high(cs[2]), .chip_select_bit_mid(cs[1]), .chip_select_bit_low(cs[0]),
      .wpIn(wp), .progBusy(busy), .standby(stby));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      testsRun++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic ackIs(input logic e);
      check({7'h00, ack}, {7'h00, e});
   endtask
   task automatic finalReport;
      $display("comparisons %0d mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic setAddr(input logic [12:0] a);
      ctrl.start();
      ctrl.xfer({4'hA, cs, 1'b0}, 1'b1, q, ack);
      ackIs(1'b0);
      ctrl.xfer({3'h0, a[12:8]}, 1'b1, q, ack);
      ackIs(1'b0);
      ctrl.xfer(a[7:0], 1'b1, q, ack);
      ackIs(1'b0);
      cnt = a;
   endtask
   task automatic wrPage(input logic [12:0] a, input int n);
      logic [7:0] d;
      setAddr(a);
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         ctrl.xfer(d, 1'b1, q, ack);
         ackIs(1'b0);
         if (!wp) mdl[{a[12:5], 5'(a[4:0] + i)}] = d;
      end
      ctrl.stop();
   endtask
   task automatic rdSeq(input int n);
      ctrl.start();
      ctrl.xfer({4'hA, cs, 1'b1}, 1'b1, q, ack);
      ackIs(1'b0);
      for (int i = 0; i < n; i++) begin
         ctrl.xfer(8'hFF, i == n - 1, q, ack);
         check(q, mdl[cnt]);
         ackIs(i == n - 1);
         cnt = (cnt + 1) % 8192;
      end
      ctrl.stop();
   endtask
   // bounded wait; a hang is a mismatch
   task automatic waitIdle;
      int k;
      k = 0;
      while (busy !== 1'b0 && k < 2 * WC) begin
         @(negedge clk);
         k++;
      end
      check(8'(k / WC), 8'h00);
      if (busy !== 1'b0) finalReport();
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      rstn = 1'b0;
      wp = 1'b0;
      seed = 73822;
      cs = 3'($random(seed));
      miscompares = 0;
      testsRun = 0;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      check({6'h00, stby, busy}, 8'h02);
      ctrl.start();
      ctrl.xfer({4'hA, ~cs, 1'b0}, 1'b1, q, ack);
      ackIs(1'b1);
      ctrl.xfer(8'h00, 1'b1, q, ack);
      ackIs(1'b1);
      ctrl.stop();
      wrPage(13'h001E, 4);
      check({7'h00, busy}, 8'h01);
      ctrl.start();
      ctrl.xfer({4'hA, cs, 1'b0}, 1'b1, q, ack);
      ackIs(1'b1);
      ctrl.stop();
      waitIdle();
      wrPage(13'h1FFF, 1);
      waitIdle();
      wp = 1'b1;
      wrPage(13'h001F, 1);
      ctrl.hold(2);
      check({7'h00, busy}, 8'h00);
      wp = 1'b0;
      setAddr(13'h1FFF);
      rdSeq(2);
      rdSeq(1);
      setAddr(13'h001E);
      rdSeq(2);
      ctrl.hold(2);
      check({6'h00, stby, busy}, 8'h02);
      finalReport();
   end
   initial begin
      repeat (90000) @(posedge clk);
      miscompares++;
      finalReport();
   end
endmodule
`default_nettype wire
